// ==== include/ufb_pkg.sv ====
package ufb_pkg;
   localparam int EP_NUM_W = 4;
   localparam int CTX_W = 5;
   localparam int NCTX = 32;
   localparam int FIFO_AW = 9;
   localparam int FSZ_W = 11;
   localparam int PSZ_W = 13;
   localparam int KIND_W = 5;
   localparam logic [7:0] OFS_PACKET_SIZE = 8'h04;
   localparam logic [7:0] OFS_BYTE_COUNT = 8'h1C;
   localparam logic [7:0] OFS_FIFO_WINDOW = 8'h20;
   localparam logic [7:0] OFS_KIND = 8'h8C;
   localparam int FSZ_LSB = 0;
   localparam int NTR_LSB = 11;
   localparam int SUPPRESS_ZLP_BIT = 4;
   localparam int ENABLE_BIT = 3;
   localparam int DOUBLE_BUF_BIT = 2;
   localparam int KIND_SEL_LSB = 0;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [1:0] NTR_RESERVED = 2'h3;
   localparam logic [10:0] EP0_SIZE_DEF = 11'h040;
   typedef enum logic [1:0] {
      KIND_CONTROL = 2'h0,
      KIND_ISOCHRONOUS = 2'h1,
      KIND_BULK = 2'h2,
      KIND_INTERRUPT = 2'h3
   } ufb_kind_t;
endpackage : ufb_pkg

// ==== src/ufb_in_sizer.sv ====
module ufb_in_sizer (
   input wire logic [ufb_pkg::FSZ_W-1:0] fill,
   input wire logic [ufb_pkg::FSZ_W-1:0] max_size,
   output logic [ufb_pkg::FSZ_W-1:0] pkt_len,
   output logic pkt_full
);
   import ufb_pkg::*;
   // one packet carries at most the configured size; the rest is dropped when the packet is acknowledged
   always_comb begin
      if (fill > max_size) begin
         pkt_len = max_size;
      end else begin
         pkt_len = fill;
      end
      pkt_full = (pkt_len == max_size) && (max_size != '0);
   end
endmodule : ufb_in_sizer

// ==== src/ufb_lane_pick.sv ====
module ufb_lane_pick (
   input wire logic word_mode,
   input wire logic [15:0] remain,
   input wire logic [7:0] byte0,
   input wire logic [7:0] byte1,
   output logic [15:0] rdata,
   output logic [1:0] step
);
   import ufb_pkg::*;
   always_comb begin
      rdata = RST_WORD;
      step = 2'h0;
      if (remain != 16'h0000) begin
         if (word_mode && remain > 16'h0001) begin
            rdata = {byte1, byte0};
            step = 2'h2;
         end else begin
            // a lone last byte always sits in the low lane
            rdata = {8'h00, byte0};
            step = 2'h1;
         end
      end
   end
endmodule : ufb_lane_pick

// ==== src/ufb_endpoint_buffer.sv ====
// Operation
// - data port is a 16-bit FIFO window; upper byte ignored on 8-bit bus
// - IN data port write advances transmit pointer by two or one
// - OUT data port read advances receive pointer by two or one
// - processor clears receive buffer or reads it empty; only then a new OUT packet is taken
// - byte count register holds 16-bit count, software may overwrite it
// - USB bus reset forces the byte count to zero
// - IN buffer validates itself once filled bytes reach the packet size
// - each sent IN packet lowers the byte count by bytes sent
// - nonzero remainder below packet size validates itself as short packet
// - count reaching zero appends empty packet unless suppress bit set
// - acknowledged OUT packet loads byte count with received length
// - reading count bytes from OUT FIFO clears receive buffer itself
// - odd last byte on 16-bit bus appears in low lane
// - packet size write reloads all byte counts with FIFO size field
// - 2-bit field gives one to three packets per microframe, 3 reserved
// - 11-bit FIFO size field sets endpoint FIFO size in bytes; endpoint 0 keeps the fixed EP0_SIZE instead
// - FIFO size zero disables the endpoint
// - kind register bits: suppress 4, enable 3, double 2, kind 1:0
// - kind codes control 0, isochronous 1, bulk 2, interrupt 3
// - registers act on endpoint and direction picked by index
// - enable bit activates indexed FIFO, clearing it disables FIFO
// - validate pulse readies transmit FIFO, clear pulse empties receive FIFO
module ufb_endpoint_buffer #(
   parameter logic [ufb_pkg::FSZ_W-1:0] EP0_SIZE = ufb_pkg::EP0_SIZE_DEF
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic usb_bus_reset,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic bus_is_8bit,
   input wire logic [ufb_pkg::EP_NUM_W-1:0] endpoint_number_select,
   input wire logic direction_is_in,
   input wire logic validate_tx_buffer,
   input wire logic clear_rx_buffer,
   output logic [15:0] reg_rdata,
   input wire logic [ufb_pkg::EP_NUM_W-1:0] usb_ep_num,
   input wire logic usb_in_token,
   input wire logic usb_tx_rd,
   input wire logic usb_in_ack,
   input wire logic usb_out_wr,
   input wire logic [7:0] usb_out_data,
   input wire logic usb_out_ack,
   input wire logic [ufb_pkg::FSZ_W-1:0] usb_out_len,
   output logic usb_in_go,
   output logic usb_in_nak,
   output logic [ufb_pkg::FSZ_W-1:0] usb_in_len,
   output logic [7:0] usb_tx_data,
   output logic usb_out_accept,
   output logic [1:0] usb_trans_limit
);
   import ufb_pkg::*;

   typedef struct packed {
      logic [NCTX-1:0][15:0] count;
      logic [NCTX-1:0][FSZ_W-1:0] fill;
      logic [NCTX-1:0][FSZ_W-1:0] sie_ptr;
      logic [NCTX-1:0][PSZ_W-1:0] psize;
      logic [NCTX-1:0][KIND_W-1:0] kind;
      logic [NCTX-1:0] tx_ready;
      logic [NCTX-1:0] rx_full;
      logic [NCTX-1:0] zlp_pend;
      logic in_busy;
      logic [CTX_W-1:0] in_ctx;
      logic [15:0] rdata;
      logic in_go;
      logic in_nak;
      logic [FSZ_W-1:0] in_len;
      logic [7:0] tx_data;
      logic out_accept;
      logic [1:0] trans;
   } ufb_state_t;

   ufb_state_t s_ff;
   ufb_state_t nxt_s;
   logic [7:0] mem [NCTX*(2**FIFO_AW)];

   logic [CTX_W-1:0] cx;
   logic [CTX_W-1:0] ic;
   logic [CTX_W-1:0] oc;
   logic [15:0] wd;
   logic [FSZ_W-1:0] in_pkt_len;
   logic in_pkt_full;
   logic [15:0] lane_rdata;
   logic [1:0] lane_step;
   logic [15:0] rd_remain;
   logic cpu_we0;
   logic cpu_we1;
   logic sie_we;
   logic [CTX_W+FIFO_AW-1:0] cpu_a0;
   logic [CTX_W+FIFO_AW-1:0] cpu_a1;
   logic [CTX_W+FIFO_AW-1:0] sie_a;
   logic [FSZ_W-1:0] fill_sum;
   logic rd_done_evt;

   function automatic logic [FSZ_W-1:0] max_of(input ufb_state_t st, input logic [CTX_W-1:0] c);
      if (c[CTX_W-1:1] == '0) begin
         max_of = EP0_SIZE;
      end else begin
         max_of = st.psize[c][FSZ_LSB+:FSZ_W];
      end
   endfunction : max_of

   function automatic logic active_of(input ufb_state_t st, input logic [CTX_W-1:0] c);
      active_of = st.kind[c][ENABLE_BIT] && (max_of(st, c) != '0);
   endfunction : active_of

   assign cx = {endpoint_number_select, direction_is_in};
   assign ic = {usb_ep_num, 1'b1};
   assign oc = {usb_ep_num, 1'b0};
   assign wd = bus_is_8bit ? {8'h00, reg_wdata[7:0]} : reg_wdata;
   assign rd_remain = s_ff.count[cx] - {5'h00, s_ff.fill[cx]};

   ufb_in_sizer u_sizer (
      .fill(s_ff.fill[ic]),
      .max_size(max_of(s_ff, ic)),
      .pkt_len(in_pkt_len),
      .pkt_full(in_pkt_full)
   );

   ufb_lane_pick u_lane (
      .word_mode(!bus_is_8bit),
      .remain(s_ff.rx_full[cx] ? rd_remain : 16'h0000),
      .byte0(mem[{cx, s_ff.fill[cx][FIFO_AW-1:0]}]),
      .byte1(mem[{cx, s_ff.fill[cx][FIFO_AW-1:0] + 9'h001}]),
      .rdata(lane_rdata),
      .step(lane_step)
   );

   always_comb begin
      nxt_s = s_ff;
      nxt_s.in_go = 1'b0;
      nxt_s.in_nak = 1'b0;
      cpu_we0 = 1'b0;
      cpu_we1 = 1'b0;
      sie_we = 1'b0;
      cpu_a0 = {cx, s_ff.fill[cx][FIFO_AW-1:0]};
      cpu_a1 = {cx, s_ff.fill[cx][FIFO_AW-1:0] + 9'h001};
      sie_a = {oc, s_ff.sie_ptr[oc][FIFO_AW-1:0]};
      fill_sum = s_ff.fill[cx];
      rd_done_evt = 1'b0;
      // processor side, indexed endpoint only, except the packet size write, which reloads every byte count
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_PACKET_SIZE: begin
               if (cx[CTX_W-1:1] != '0) begin
                  nxt_s.psize[cx] = wd[PSZ_W-1:0];
               end
               for (int i = 0; i < NCTX; i++) begin
                  nxt_s.count[i] = {5'h00, wd[FSZ_LSB+:FSZ_W]};
               end
            end
            OFS_BYTE_COUNT: nxt_s.count[cx] = wd;
            OFS_KIND: nxt_s.kind[cx] = wd[KIND_W-1:0];
            OFS_FIFO_WINDOW: begin
               if (direction_is_in && active_of(s_ff, cx) && !s_ff.tx_ready[cx]) begin
                  cpu_we0 = 1'b1;
                  cpu_we1 = !bus_is_8bit;
                  fill_sum = s_ff.fill[cx] + (bus_is_8bit ? 11'h001 : 11'h002);
                  nxt_s.fill[cx] = fill_sum;
                  if (fill_sum >= max_of(s_ff, cx)) begin
                     nxt_s.tx_ready[cx] = 1'b1;
                  end
                  if ({5'h00, fill_sum} == s_ff.count[cx] &&
                      s_ff.count[cx] < {5'h00, max_of(s_ff, cx)}) begin
                     nxt_s.tx_ready[cx] = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_PACKET_SIZE: nxt_s.rdata = {3'h0, s_ff.psize[cx]};
            OFS_BYTE_COUNT: nxt_s.rdata = s_ff.count[cx];
            OFS_KIND: nxt_s.rdata = {11'h000, s_ff.kind[cx]};
            OFS_FIFO_WINDOW: begin
               nxt_s.rdata = lane_rdata;
               if (!direction_is_in && lane_step != 2'h0) begin
                  fill_sum = s_ff.fill[cx] + {9'h000, lane_step};
                  nxt_s.fill[cx] = fill_sum;
                  if ({5'h00, fill_sum} >= s_ff.count[cx]) begin
                     rd_done_evt = 1'b1;
                     nxt_s.rx_full[cx] = 1'b0;
                     nxt_s.fill[cx] = '0;
                  end
               end
            end
            default: nxt_s.rdata = RST_WORD;
         endcase
         if (bus_is_8bit) begin
            nxt_s.rdata[15:8] = 8'h00;
         end
      end
      if (validate_tx_buffer && direction_is_in && active_of(s_ff, cx)) begin
         nxt_s.tx_ready[cx] = 1'b1;
      end
      if (clear_rx_buffer && !direction_is_in) begin
         nxt_s.rx_full[cx] = 1'b0;
         nxt_s.fill[cx] = '0;
         nxt_s.sie_ptr[cx] = '0;
      end
      // usb side; a packet set in the same cycle as a clear survives
      if (usb_in_token && !s_ff.in_busy) begin
         if (s_ff.tx_ready[ic] && active_of(s_ff, ic)) begin
            nxt_s.in_go = 1'b1;
            nxt_s.in_len = in_pkt_len;
            nxt_s.in_busy = 1'b1;
            nxt_s.in_ctx = ic;
            nxt_s.sie_ptr[ic] = '0;
         end else if (s_ff.zlp_pend[ic]) begin
            nxt_s.in_go = 1'b1;
            nxt_s.in_len = '0;
            nxt_s.zlp_pend[ic] = 1'b0;
         end else begin
            nxt_s.in_nak = 1'b1;
         end
      end
      if (usb_tx_rd && s_ff.in_busy) begin
         nxt_s.tx_data = mem[{s_ff.in_ctx, s_ff.sie_ptr[s_ff.in_ctx][FIFO_AW-1:0]}];
         nxt_s.sie_ptr[s_ff.in_ctx] = s_ff.sie_ptr[s_ff.in_ctx] + 11'h001;
      end
      if (usb_in_ack && s_ff.in_busy) begin
         nxt_s.in_busy = 1'b0;
         nxt_s.tx_ready[s_ff.in_ctx] = 1'b0;
         nxt_s.fill[s_ff.in_ctx] = '0;
         if (s_ff.count[s_ff.in_ctx] > {5'h00, s_ff.in_len}) begin
            nxt_s.count[s_ff.in_ctx] = s_ff.count[s_ff.in_ctx] - {5'h00, s_ff.in_len};
         end else begin
            nxt_s.count[s_ff.in_ctx] = 16'h0000;
            if (!s_ff.kind[s_ff.in_ctx][SUPPRESS_ZLP_BIT] && s_ff.in_len != '0) begin
               nxt_s.zlp_pend[s_ff.in_ctx] = 1'b1;
            end
         end
      end
      if (usb_out_wr && !s_ff.rx_full[oc] && active_of(s_ff, oc)) begin
         sie_we = 1'b1;
         nxt_s.sie_ptr[oc] = s_ff.sie_ptr[oc] + 11'h001;
      end
      if (usb_out_ack && !s_ff.rx_full[oc] && active_of(s_ff, oc)) begin
         nxt_s.count[oc] = {5'h00, usb_out_len};
         nxt_s.rx_full[oc] = 1'b1;
         nxt_s.sie_ptr[oc] = '0;
         nxt_s.fill[oc] = '0;
      end
      nxt_s.out_accept = !s_ff.rx_full[oc] && active_of(s_ff, oc);
      if (s_ff.psize[ic][NTR_LSB+:2] == NTR_RESERVED) begin
         nxt_s.trans = 2'h0;
      end else begin
         nxt_s.trans = s_ff.psize[ic][NTR_LSB+:2];
      end
      if (usb_bus_reset) begin
         nxt_s = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // per-context FIFO storage, indexed by context and byte pointer
   always_ff @(posedge ref_clk) begin
      if (cpu_we0) begin
         mem[cpu_a0] <= wd[7:0];
      end
      if (cpu_we1) begin
         mem[cpu_a1] <= wd[15:8];
      end
      if (sie_we) begin
         mem[sie_a] <= usb_out_data;
      end
   end

   assign reg_rdata = s_ff.rdata;
   assign usb_in_go = s_ff.in_go;
   assign usb_in_nak = s_ff.in_nak;
   assign usb_in_len = s_ff.in_len;
   assign usb_tx_data = s_ff.tx_data;
   assign usb_out_accept = s_ff.out_accept;
   assign usb_trans_limit = s_ff.trans;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   property p_bus_reset_zero;
      usb_bus_reset |=> (s_ff.count == '0) && !usb_in_go && (reg_rdata == RST_WORD);
   endproperty
   a_bus_reset_zero: assert property (p_bus_reset_zero) else $error("bus reset left state");

   property p_size_reload;
      (reg_wr && reg_addr == OFS_PACKET_SIZE && !usb_bus_reset && !usb_in_ack && !usb_out_ack)
         |=> (s_ff.count[NCTX-1] == {5'h00, $past(wd[10:0])});
   endproperty
   a_size_reload: assert property (p_size_reload) else $error("count not reloaded");

   property p_in_advance;
      (reg_wr && reg_addr == OFS_FIFO_WINDOW && direction_is_in && cpu_we0 && !usb_bus_reset
         && !(usb_in_ack && s_ff.in_busy && s_ff.in_ctx == cx))
         |=> (s_ff.fill[$past(cx)] == $past(s_ff.fill[cx]) + ($past(bus_is_8bit) ? 11'h001 : 11'h002));
   endproperty
   a_in_advance: assert property (p_in_advance) else $error("tx pointer step wrong");

   property p_out_load;
      (usb_out_ack && nxt_s.rx_full[oc] && !s_ff.rx_full[oc] && !usb_bus_reset)
         |=> (s_ff.count[$past(oc)] == {5'h00, $past(usb_out_len)}) && s_ff.rx_full[$past(oc)];
   endproperty
   a_out_load: assert property (p_out_load) else $error("out count not loaded");

   property p_read_done;
      (rd_done_evt && !usb_bus_reset && !(usb_out_ack && oc == cx)) |=> !s_ff.rx_full[$past(cx)];
   endproperty
   a_read_done: assert property (p_read_done) else $error("rx buffer not cleared");

   property p_size_zero_off;
      (usb_ep_num != '0 && s_ff.psize[oc][FSZ_W-1:0] == '0) |=> !usb_out_accept;
   endproperty
   a_size_zero_off: assert property (p_size_zero_off) else $error("zero size accepts");

   property p_trans_legal;
      usb_trans_limit != NTR_RESERVED;
   endproperty
   a_trans_legal: assert property (p_trans_legal) else $error("reserved transaction code");

   property p_validate;
      (validate_tx_buffer && direction_is_in && active_of(s_ff, cx) && !usb_bus_reset
         && !(usb_in_ack && s_ff.in_busy)) |=> s_ff.tx_ready[$past(cx)];
   endproperty
   a_validate: assert property (p_validate) else $error("validate ignored");

   property p_zlp;
      (usb_in_ack && s_ff.in_busy && s_ff.count[s_ff.in_ctx] <= {5'h00, s_ff.in_len}
         && s_ff.in_len != '0 && !usb_bus_reset)
         |=> (s_ff.zlp_pend[$past(s_ff.in_ctx)] == !$past(s_ff.kind[s_ff.in_ctx][SUPPRESS_ZLP_BIT]));
   endproperty
   a_zlp: assert property (p_zlp) else $error("empty packet rule broken");

   property p_odd_low;
      (reg_rd && reg_addr == OFS_FIFO_WINDOW && lane_step == 2'h1) |=> (reg_rdata[15:8] == 8'h00);
   endproperty
   a_odd_low: assert property (p_odd_low) else $error("odd byte not in low lane");

   c_in_packet: cover property (usb_in_go && usb_in_len != '0);
   c_zlp_sent: cover property (usb_in_go && usb_in_len == '0);
   c_out_read_done: cover property (rd_done_evt);
endmodule : ufb_endpoint_buffer

// ==== verification/ufb_cpu_model.sv ====
// processor on the parallel register bus: indexes, fills, drains, validates, clears
module ufb_cpu_model (
   input wire logic ref_clk,
   input wire logic [15:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [15:0] reg_wdata,
   output logic bus_is_8bit,
   output logic [ufb_pkg::EP_NUM_W-1:0] endpoint_number_select,
   output logic direction_is_in,
   output logic validate_tx_buffer,
   output logic clear_rx_buffer
);
   timeunit 1ns;
   timeprecision 1ps;
   import ufb_pkg::*;
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
      bus_is_8bit = 1'b0;
      endpoint_number_select = 4'h0;
      direction_is_in = 1'b0;
      validate_tx_buffer = 1'b0;
      clear_rx_buffer = 1'b0;
   end
   task automatic sel(input logic [3:0] ep, input logic dir_in);
      @(posedge ref_clk);
      endpoint_number_select <= ep;
      direction_is_in <= dir_in;
   endtask : sel
   task automatic set8(input logic b);
      @(posedge ref_clk);
      bus_is_8bit <= b;
   endtask : set8
   // idle bus lines show the inverse of the last value, never a stale copy
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge ref_clk);
      #1;
      d = reg_rdata;
   endtask : rd
   // vld high: validate the filled tx buffer, low: clear the drained rx buffer
   task automatic ctl(input logic vld);
      @(posedge ref_clk);
      if (vld)
         validate_tx_buffer <= 1'b1;
      else
         clear_rx_buffer <= 1'b1;
      @(posedge ref_clk);
      validate_tx_buffer <= 1'b0;
      clear_rx_buffer <= 1'b0;
   endtask : ctl
endmodule : ufb_cpu_model

// ==== verification/test_usb_endpoint_buffer_access.sv ====
module test_usb_endpoint_buffer_access;
   timeunit 1ns;
   timeprecision 1ps;
   import ufb_pkg::*;
   logic ref_clk = 1'b0;
   logic srst;
   logic usb_bus_reset;
   logic [7:0] reg_addr, usb_out_data, usb_tx_data;
   logic [15:0] reg_wdata, reg_rdata, v;
   logic reg_wr, reg_rd, bus_is_8bit, direction_is_in, validate_tx_buffer, clear_rx_buffer;
   logic [3:0] endpoint_number_select, usb_ep_num;
   logic usb_in_token, usb_tx_rd, usb_in_ack;
   logic usb_out_wr, usb_out_ack;
   logic [10:0] usb_out_len, usb_in_len;
   logic usb_in_go, usb_in_nak, usb_out_accept;
   logic [1:0] usb_trans_limit;
   logic [31:0] seed = 32'h00015F32;
   logic [7:0] tx_q[$];
   logic [7:0] ob[$];
   int err_count = 0;
   int compares = 0;
   int cycles = 0;

   always #12.5 ref_clk = ~ref_clk;

   ufb_cpu_model cpu (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .bus_is_8bit(bus_is_8bit),
      .endpoint_number_select(endpoint_number_select), .direction_is_in(direction_is_in),
      .validate_tx_buffer(validate_tx_buffer), .clear_rx_buffer(clear_rx_buffer));

   ufb_endpoint_buffer dut (.ref_clk(ref_clk), .srst(srst), .usb_bus_reset(usb_bus_reset),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .bus_is_8bit(bus_is_8bit), .endpoint_number_select(endpoint_number_select),
      .direction_is_in(direction_is_in), .validate_tx_buffer(validate_tx_buffer),
      .clear_rx_buffer(clear_rx_buffer), .reg_rdata(reg_rdata), .usb_ep_num(usb_ep_num),
      .usb_in_token(usb_in_token), .usb_tx_rd(usb_tx_rd), .usb_in_ack(usb_in_ack),
      .usb_out_wr(usb_out_wr), .usb_out_data(usb_out_data), .usb_out_ack(usb_out_ack),
      .usb_out_len(usb_out_len), .usb_in_go(usb_in_go), .usb_in_nak(usb_in_nak),
      .usb_in_len(usb_in_len), .usb_tx_data(usb_tx_data), .usb_out_accept(usb_out_accept),
      .usb_trans_limit(usb_trans_limit));

   task automatic final_report;
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         err_count = err_count + 1;
         final_report();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      cpu.rd(a, v);
      chk(v, exp);
   endtask : rdchk

   // one data port write; the model queue keeps the byte order the host must see
   task automatic put(input logic eight);
      logic [31:0] r;
      r = xs();
      tx_q.push_back(r[7:0]);
      if (!eight)
         tx_q.push_back(r[15:8]);
      cpu.wr(OFS_FIFO_WINDOW, r[15:0]);
   endtask : put

   task automatic look(input logic [3:0] ep);
      @(posedge ref_clk);
      usb_ep_num <= ep;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : look

   // IN token on endpoint 1, then drain and acknowledge when a packet goes
   task automatic in_pkt(input logic exp_go, input int len);
      repeat (2) @(posedge ref_clk);
      usb_ep_num <= 4'h1;
      usb_in_token <= 1'b1;
      @(posedge ref_clk);
      usb_in_token <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         #1;
         if (usb_in_go === 1'b1 || usb_in_nak === 1'b1)
            break;
         @(posedge ref_clk);
      end
      chk(16'({usb_in_go, usb_in_nak}), exp_go ? 16'h0002 : 16'h0001);
      if (exp_go) begin
         chk(16'(usb_in_len), 16'(len));
         repeat (len) begin
            @(posedge ref_clk);
            usb_tx_rd <= 1'b1;
            @(posedge ref_clk);
            usb_tx_rd <= 1'b0;
            @(posedge ref_clk);
            #1;
            chk(16'(usb_tx_data), 16'(tx_q.pop_front()));
         end
         @(posedge ref_clk);
         usb_in_ack <= 1'b1;
         @(posedge ref_clk);
         usb_in_ack <= 1'b0;
      end
      repeat (2) @(posedge ref_clk);
   endtask : in_pkt

   // OUT packet of n random bytes to endpoint 3, strobe held across bytes
   task automatic out_pkt(input int n);
      logic [31:0] r;
      ob.delete();
      for (int i = 0; i < n; i++) begin
         r = xs();
         ob.push_back(r[7:0]);
         @(posedge ref_clk);
         usb_ep_num <= 4'h3;
         usb_out_wr <= 1'b1;
         usb_out_data <= r[7:0];
      end
      @(posedge ref_clk);
      usb_out_wr <= 1'b0;
      usb_out_data <= ~usb_out_data;
      usb_out_ack <= 1'b1;
      usb_out_len <= 11'(n);
      @(posedge ref_clk);
      usb_out_ack <= 1'b0;
   endtask : out_pkt

   initial begin
      srst <= 1'b1;
      usb_bus_reset <= 1'b0;
      usb_out_data <= 8'h00;
      usb_ep_num <= 4'h0;
      usb_in_token <= 1'b0;
      usb_tx_rd <= 1'b0;
      usb_in_ack <= 1'b0;
      usb_out_wr <= 1'b0;
      usb_out_ack <= 1'b0;
      usb_out_len <= 11'h000;
      repeat (4) @(posedge ref_clk);
      srst <= 1'b0;
      cpu.sel(4'h1, 1'b1);
      rdchk(OFS_PACKET_SIZE, RST_WORD);
      rdchk(OFS_BYTE_COUNT, RST_WORD);
      rdchk(OFS_FIFO_WINDOW, RST_WORD);
      rdchk(OFS_KIND, RST_WORD);
      rdchk(8'h10, RST_WORD);
      $display("test reset values done");
      for (int k = 0; k < 4; k++) begin
         cpu.wr(OFS_KIND, 16'hFFE8 | 16'(k));
         rdchk(OFS_KIND, 16'h0008 | 16'(k));
      end
      cpu.wr(OFS_KIND, 16'h000A);
      cpu.wr(OFS_PACKET_SIZE, 16'h1808);
      look(4'h1);
      chk(16'(usb_trans_limit), 16'h0000);
      cpu.wr(OFS_PACKET_SIZE, 16'h1008);
      rdchk(OFS_PACKET_SIZE, 16'h1008);
      look(4'h1);
      chk(16'(usb_trans_limit), 16'h0002);
      rdchk(OFS_BYTE_COUNT, 16'h0008);
      cpu.sel(4'h2, 1'b0);
      rdchk(OFS_BYTE_COUNT, 16'h0008);
      cpu.wr(OFS_KIND, 16'h0008);
      look(4'h2);
      chk(16'(usb_out_accept), 16'h0000);
      cpu.sel(4'h0, 1'b1);
      cpu.wr(OFS_PACKET_SIZE, 16'h0010);
      rdchk(OFS_PACKET_SIZE, RST_WORD);
      rdchk(OFS_BYTE_COUNT, 16'h0010);
      $display("test configuration done");
      cpu.sel(4'h1, 1'b0);
      cpu.wr(OFS_BYTE_COUNT, 16'h0033);
      cpu.sel(4'h1, 1'b1);
      cpu.wr(OFS_BYTE_COUNT, 16'h000A);
      rdchk(OFS_BYTE_COUNT, 16'h000A);
      cpu.sel(4'h1, 1'b0);
      rdchk(OFS_BYTE_COUNT, 16'h0033);
      cpu.sel(4'h1, 1'b1);
      repeat (3) put(1'b0);
      in_pkt(1'b0, 0);
      put(1'b0);
      in_pkt(1'b1, 8);
      rdchk(OFS_BYTE_COUNT, 16'h0002);
      put(1'b0);
      in_pkt(1'b1, 2);
      rdchk(OFS_BYTE_COUNT, 16'h0000);
      in_pkt(1'b1, 0);
      in_pkt(1'b0, 0);
      cpu.wr(OFS_KIND, 16'h001A);
      cpu.set8(1'b1);
      put(1'b1);
      cpu.ctl(1'b1);
      in_pkt(1'b1, 1);
      in_pkt(1'b0, 0);
      cpu.set8(1'b0);
      $display("test in transfers done");
      cpu.sel(4'h3, 1'b0);
      cpu.wr(OFS_KIND, 16'h000A);
      cpu.wr(OFS_PACKET_SIZE, 16'h0008);
      look(4'h3);
      chk(16'(usb_out_accept), 16'h0001);
      out_pkt(5);
      look(4'h3);
      chk(16'(usb_out_accept), 16'h0000);
      rdchk(OFS_BYTE_COUNT, 16'h0005);
      rdchk(OFS_FIFO_WINDOW, {ob[1], ob[0]});
      rdchk(OFS_FIFO_WINDOW, {ob[3], ob[2]});
      rdchk(OFS_FIFO_WINDOW, {8'h00, ob[4]});
      look(4'h3);
      chk(16'(usb_out_accept), 16'h0001);
      out_pkt(3);
      cpu.set8(1'b1);
      rdchk(OFS_FIFO_WINDOW, {8'h00, ob[0]});
      rdchk(OFS_FIFO_WINDOW, {8'h00, ob[1]});
      cpu.set8(1'b0);
      look(4'h3);
      chk(16'(usb_out_accept), 16'h0000);
      cpu.ctl(1'b0);
      look(4'h3);
      chk(16'(usb_out_accept), 16'h0001);
      $display("test out transfers done");
      cpu.wr(OFS_BYTE_COUNT, 16'h1234);
      rdchk(OFS_BYTE_COUNT, 16'h1234);
      @(posedge ref_clk);
      usb_bus_reset <= 1'b1;
      @(posedge ref_clk);
      usb_bus_reset <= 1'b0;
      rdchk(OFS_BYTE_COUNT, RST_WORD);
      rdchk(OFS_KIND, RST_WORD);
      $display("test bus reset done");
      final_report();
   end
endmodule : test_usb_endpoint_buffer_access
